/* File: include/rdt_pkg.sv */
// constants for the reload down timer set
// assumes one system clock and synchronous pins
package rdt_pkg;
  localparam int RDT_CNT_W = 16;
  localparam int RDT_NUM_TIMERS = 6;
  localparam int RDT_NUM_EVENT = 4;
  localparam int RDT_PRE_W = 8;
  localparam logic [15:0] RDT_CNT_RST = 16'h0000;
  localparam logic [7:0] RDT_PRE_RST = 8'h00;
  // prescaler taps, indexed by the two-bit select
  localparam logic [7:0] RDT_TAP_DIV4 = 8'h03;
  localparam logic [7:0] RDT_TAP_DIV16 = 8'h0f;
  localparam logic [7:0] RDT_TAP_DIV64 = 8'h3f;
  localparam logic [7:0] RDT_TAP_DIV256 = 8'hff;
  localparam real RDT_CLK_MHZ = 200.0;
endpackage

/* File: logic/rdt_channel.sv */
// one 16-bit reloadable down counter with prescaler
// assumes controls are steady or change synchronously to clk_i
`timescale 1ns/1ps
module rdt_channel
  import rdt_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter bit HAS_EVENT = 1'b0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // control
  input wire logic enable_i,
  input wire logic clk_gate_i,
  input wire logic continuous_i,
  input wire logic [1:0] prescale_sel_i,
  input wire logic event_sel_i,
  input wire logic event_pin_i,
  input wire logic [CNT_W-1:0] reload_i,
  // status
  output logic [CNT_W-1:0] count_o,
  output logic zero_pulse_o,
  output logic running_o,
  output logic toggle_o
);
  logic [RDT_PRE_W-1:0] pre_q, pre_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic run_q, run_d, ev_q, ev_d, zp_q, zp_d, tg_q, tg_d;
  logic [RDT_PRE_W-1:0] tap;
  logic tick, use_event;

  assign use_event = HAS_EVENT && event_sel_i;

  always_comb begin
    unique case (prescale_sel_i)
      2'd0: tap = RDT_TAP_DIV4;
      2'd1: tap = RDT_TAP_DIV16;
      2'd2: tap = RDT_TAP_DIV64;
      2'd3: tap = RDT_TAP_DIV256;
    endcase
  end

  always_comb begin
    pre_d = pre_q;
    cnt_d = cnt_q;
    run_d = run_q;
    ev_d = event_pin_i;
    zp_d = 1'b0;
    tg_d = tg_q;
    tick = 1'b0;
    if (!enable_i) begin
      // disabled: arm with reload, start again on enable
      run_d = 1'b0;
      cnt_d = reload_i;
      pre_d = RDT_PRE_RST;
    end else if (clk_gate_i) begin
      ev_d = ev_q;
    end else begin
      if (!run_q && cnt_q != '0) begin
        run_d = 1'b1;
      end
      if (use_event) begin
        tick = event_pin_i && !ev_q;
      end else begin
        tick = (pre_q == tap);
        pre_d = (pre_q == tap) ? RDT_PRE_RST : pre_q + 1'b1;
      end
      if (run_q && tick) begin
        if (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1}) begin
          zp_d = 1'b1;
          // output toggles on each terminal count
          tg_d = !tg_q;
          // reload if continuous, else stop at zero
          if (continuous_i) begin
            cnt_d = reload_i;
          end else begin
            cnt_d = '0;
            run_d = 1'b0;
          end
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pre_q <= RDT_PRE_RST;
      cnt_q <= '0;
      run_q <= 1'b0;
      ev_q <= 1'b0;
      zp_q <= 1'b0;
      tg_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      cnt_q <= cnt_d;
      run_q <= run_d;
      ev_q <= ev_d;
      zp_q <= zp_d;
      tg_q <= tg_d;
    end
  end

  assign count_o = cnt_q;
  assign zero_pulse_o = zp_q;
  assign running_o = run_q;
  assign toggle_o = tg_q;

  single_stop_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    zp_q && !$past(continuous_i) |-> !run_q && cnt_q == '0)
    else $error("single pass did not stop");
  cont_reload_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    zp_q && $past(continuous_i) && $past(enable_i) |-> cnt_q == $past(reload_i))
    else $error("continuous did not reload");
  gate_freeze_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    enable_i && clk_gate_i ##1 enable_i |-> $stable(cnt_q) && !zp_q)
    else $error("count moved while gated");
  out_toggle_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    zp_q |-> tg_q != $past(tg_q))
    else $error("output did not toggle");
  // count steps down by at most one
  step_down_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $past(run_q) && run_q && enable_i && !zp_q && $past(enable_i) |->
      cnt_q == $past(cnt_q) || cnt_q == $past(cnt_q) - 1'b1)
    else $error("count not a down step");
endmodule

/* File: logic/rdt_timer_set.sv */
// six reloadable down timers, four with event inputs, two with outputs
// assumes controls come from outside logic; pins synchronous to clk_i
// Summary of operation
// - six independent 16-bit down counters
// - prescale clock by 4, 16, 64, 256
// - single-pass or continuous counting modes
// - four timers may count input pin events
// - two timers drive a general output pin
// - per-timer clock gate stops the timer
`timescale 1ns/1ps
module rdt_timer_set
  import rdt_pkg::*;
#(
  parameter int NUM_TIMERS = 6,
  parameter int NUM_EVENT = 4,
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // per-timer control
  input wire logic [NUM_TIMERS-1:0] enable_i,
  input wire logic [NUM_TIMERS-1:0] clk_gate_i,
  input wire logic [NUM_TIMERS-1:0] continuous_i,
  input wire logic [2*NUM_TIMERS-1:0] prescale_sel_i,
  input wire logic [NUM_TIMERS-1:0] event_sel_i,
  input wire logic [CNT_W*NUM_TIMERS-1:0] reload_i,
  // pins
  input wire logic [NUM_EVENT-1:0] event_pin_i,
  input wire logic [NUM_TIMERS-NUM_EVENT-1:0] out_en_i,
  output logic [NUM_TIMERS-NUM_EVENT-1:0] timer_pin_o,
  // status
  output logic [CNT_W*NUM_TIMERS-1:0] count_o,
  output logic [NUM_TIMERS-1:0] zero_pulse_o,
  output logic [NUM_TIMERS-1:0] running_o
);
  logic [NUM_TIMERS-1:0] toggle;
  logic [NUM_TIMERS-NUM_EVENT-1:0] pin_q, pin_d;

  for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_ch
    logic ev_pin;
    if (i < NUM_EVENT) begin : g_ev
      assign ev_pin = event_pin_i[i];
    end else begin : g_noev
      assign ev_pin = 1'b0;
    end
    rdt_channel #(
      .CNT_W(CNT_W),
      .HAS_EVENT(i < NUM_EVENT)
    ) u_ch (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .enable_i(enable_i[i]),
      .clk_gate_i(clk_gate_i[i]),
      .continuous_i(continuous_i[i]),
      .prescale_sel_i(prescale_sel_i[2*i +: 2]),
      .event_sel_i(event_sel_i[i]),
      .event_pin_i(ev_pin),
      .reload_i(reload_i[CNT_W*i +: CNT_W]),
      .count_o(count_o[CNT_W*i +: CNT_W]),
      .zero_pulse_o(zero_pulse_o[i]),
      .running_o(running_o[i]),
      .toggle_o(toggle[i])
    );
  end

  // output pin follows toggle when enabled, low otherwise
  always_comb begin
    pin_d = out_en_i & toggle[NUM_TIMERS-1:NUM_EVENT];
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_q <= '0;
    end else begin
      pin_q <= pin_d;
    end
  end

  assign timer_pin_o = pin_q;

  // pin tracks toggle one cycle later
  pin_follow_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ##1 timer_pin_o == ($past(out_en_i) & $past(toggle[NUM_TIMERS-1:NUM_EVENT])))
    else $error("output pin mismatch");
  // gated timer gives no zero pulse
  gate_quiet_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $past(clk_gate_i[0]) && $past(enable_i[0]) |-> !zero_pulse_o[0])
    else $error("zero pulse while gated");
  // a stopped single-pass timer stays at zero while still enabled
  idle_zero_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    zero_pulse_o[2] && enable_i[2] && !$past(continuous_i[2]) |=>
      count_o[CNT_W*2 +: CNT_W] == '0)
    else $error("single pass restarted");

  // per-timer checks, one copy for each channel
  for (genvar j = 0; j < NUM_TIMERS; j++) begin : g_chk
    // terminal pulse lasts one cycle only
    zp_once_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      zero_pulse_o[j] |=> !zero_pulse_o[j])
      else $error("zero pulse longer than one cycle");
    // a disabled timer holds its reload value and is stopped
    load_idle_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !enable_i[j] |=> !running_o[j] &&
        count_o[CNT_W*j +: CNT_W] == $past(reload_i[CNT_W*j +: CNT_W]))
      else $error("disabled timer not loaded");
  end
endmodule

/* File: testbench/tb_rdt_timer_set.sv */
// self-checking bench for the six reload down timers
// assumes controls are driven at the falling clock edge, no far-side model
`timescale 1ns/1ps
module tb_rdt_timer_set;
  import rdt_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [5:0] en = '0, gate = '0, cont = '0, esel = '0, zp, run;
  logic [11:0] psel = '0;
  logic [95:0] rl = '0, cnt;
  logic [3:0] pin = '0;
  logic [1:0] oen = '0, tpin, p;
  logic [15:0] v;
  int err_total = 0;
  int n_checks = 0;
  int k;

  rdt_timer_set i_rdt_timer_set (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .enable_i(en), .clk_gate_i(gate), .continuous_i(cont),
    .prescale_sel_i(psel), .event_sel_i(esel), .reload_i(rl),
    .event_pin_i(pin), .out_en_i(oen), .timer_pin_o(tpin),
    .count_o(cnt), .zero_pulse_o(zp), .running_o(run));

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic close_out();
    if (err_total == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] s);
    n_checks++;
    if (e !== s) begin
      err_total++;
      $display("mismatch %s expected %0h seen %0h", n, e, s);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // restart from a stopped state so the prescaler begins at zero
  task automatic start(input int t, input logic [1:0] s, input logic c,
                       input logic [15:0] r);
    en[t] = 1'b0;
    psel[2*t +: 2] = s;
    cont[t] = c;
    rl[16*t +: 16] = r;
    cyc(2);
    en[t] = 1'b1;
  endtask

  // the pulse lasts one cycle, so n is the exact spacing between pulses
  task automatic wait_zp(input int t, output int n);
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (zp[t] !== 1'b1 && n < 2000);
  endtask

  task automatic per(input int t, input int d, input logic [15:0] r);
    int n;
    wait_zp(t, n);
    chk("count after reload", {16'h0000, r}, {16'h0000, cnt[16*t +: 16]});
    wait_zp(t, n);
    chk("period", d * r, n);
  endtask

  task automatic t_taps();
    for (int s = 0; s < 4; s++) begin
      start(1, s[1:0], 1'b1, 16'h0003);
      per(1, 4 << (2 * s), 16'h0003);
    end
    en[1] = 1'b0;
  endtask

  task automatic t_single();
    start(2, 2'h0, 1'b0, 16'h0002);
    cyc(2);
    chk("running", 1, run[2]);
    wait_zp(2, k);
    cyc(4);
    chk("single count", 0, cnt[47:32]);
    chk("single stop", 0, run[2]);
    wait_zp(2, k);
    chk("no second pass", 2000, k);
    en[2] = 1'b0;
  endtask

  // a pin held high for several cycles is still one event
  task automatic t_event();
    esel[3] = 1'b1;
    start(3, 2'h3, 1'b1, 16'h0005);
    // running is set one edge after enable; an earlier edge is not counted
    cyc(2);
    for (int i = 0; i < 3; i++) begin
      pin[3] = 1'b1;
      cyc(i + 1);
      pin[3] = 1'b0;
      cyc(2);
    end
    cyc(3);
    chk("event count", 16'h0002, cnt[63:48]);
  endtask

  task automatic t_out();
    oen = 2'b11;
    start(4, 2'h0, 1'b1, 16'h0002);
    start(5, 2'h0, 1'b1, 16'h0002);
    wait_zp(5, k);
    cyc(2);
    p = tpin;
    wait_zp(5, k);
    cyc(2);
    chk("pin toggle", {30'h0, ~p}, tpin);
    oen = 2'b00;
    cyc(2);
    chk("pin off", 0, tpin);
  endtask

  task automatic t_gate();
    start(0, 2'h0, 1'b1, 16'hffff);
    chk("wide load", 16'hffff, cnt[15:0]);
    cyc(20);
    gate[0] = 1'b1;
    cyc(1);
    v = cnt[15:0];
    cyc(40);
    chk("gated hold", v, cnt[15:0]);
    gate[0] = 1'b0;
    cyc(10);
    chk("ungated moves", 1, cnt[15:0] !== v);
  endtask

  initial begin
    #300000;
    err_total++;
    close_out();
  end

  initial begin
    cyc(3);
    sys_rst_i = 1'b0;
    cyc(2);
    t_taps();
    t_single();
    t_event();
    t_out();
    t_gate();
    close_out();
  end
endmodule
